// *** src/aurx_pkg.sv ***
/*
  Package for the asynchronous serial receiver: register offsets, field
  positions, reset values and timing constants.
  Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package aurx_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFF_RX_DATA   = 5'h00;
  localparam logic [4:0] OFF_RX_STATUS = 5'h04;
  localparam logic [4:0] OFF_TX_STATUS = 5'h08;
  localparam logic [4:0] OFF_BAUD_DIV  = 5'h0C;
  localparam logic [4:0] OFF_IRQ_CTRL  = 5'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  // rx_status_ctrl
  localparam int BIT_PORT_EN   = 7;
  localparam int BIT_NINE_SEL  = 6;
  localparam int BIT_CONT_RX   = 4;
  localparam int BIT_ADDR_DET  = 3;
  localparam int BIT_FRAME_ERR = 2;
  localparam int BIT_OVERRUN   = 1;
  localparam int BIT_NINTH     = 0;
  // tx_status_ctrl
  localparam int BIT_SYNC_SEL  = 4;
  localparam int BIT_HIGH_SPD  = 2;
  // irq_control_reg
  localparam int BIT_RX_IRQ_EN = 0;
  localparam int BIT_PER_IRQ   = 1;
  localparam int BIT_GLB_IRQ   = 2;
  localparam int BIT_PENDING   = 3;

  // ----------------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int         OVERSAMPLE   = 16;
  localparam logic [3:0] CENTER_TICK  = 4'h7;
  localparam logic [1:0] LOW_SPD_DIV  = 2'h3;
  localparam int         FIFO_DEPTH   = 2;

endpackage

// *** src/aurx_receiver.sv ***
/*
  Asynchronous serial receiver with 16x oversampling, majority vote,
  two-entry character FIFO, framing/overrun status and 9-bit address
  detection. Registers are reached over AXI4-Lite.
  Assumes one 10 MHz clock, a synchronous active-low reset, and a remote
  transmitter idling high on the receive pin.
*/
// Functional notes
// RL1: Data recovery oversamples at sixteen times bit rate; shift register moves per bit.
// RL2: Completed characters go into a two-entry FIFO.
// RL3: Reception runs only with continuous receive on, sync off, port enabled.
// RL4: Port enable forces receive pin input, transmit pin output, latch cut.
// RL5: Falling edge, wait half bit; high level abandons character silently.
// RL6: Each data bit sampled one bit time later by majority, then shifted.
// RL7: Stop position low marks framing error, high marks clean character.
// RL8: After stop bit, character moves to FIFO and pending flag rises.
// RL9: Reading receive data returns oldest character and removes it.
// RL10: Pending flag is enabled-and-nonempty, read only.
// RL11: Interrupt request needs all three enables; flag ignores enables.
// RL12: Framing bit stored per entry; flag shows head entry.
// RL13: Framing flag read only, needs no clearing, never stops reception, no interrupt.
// RL14: Port enable clear resets receiver and framing flag; receive enable clear keeps it.
// RL15: Third character into full FIFO sets overrun; further characters refused.
// RL16: Clearing receive enable or port enable clears overrun.
// RL17: Nine-bit mode shifts nine bits; ninth of head shown in status.
// RL18: Address detection with nine bits keeps only ninth-bit-set characters.
// RL19: Software clears address detection after own address, sets again later.
// RL20: Software configures baud, port, interrupts, modes, then receive enable.
// RL21: Data arrive least significant bit first.
// RL22: Bit rate is clock over 64(n+1) low speed, 16(n+1) high speed.
// RL23: Writing the baud divisor restarts the baud timer at once.
// RL24: Majority vote of three oversamples around centre.
`timescale 1ns/1ns
`default_nettype none

module aurx_receiver (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // AXI4-Lite write channels
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial pins
  input  wire logic        receive_pin_in,
  output logic             receive_pin_out,
  output logic             receive_pin_oe,
  output logic             transmit_pin_out,
  output logic             transmit_pin_oe,
  // Port controls used when the serial port is off, plus tx_serial_data, driven out when it is on
  input  wire logic        pin_direction_rx,
  input  wire logic        pin_direction_tx,
  input  wire logic        port_latch_rx,
  input  wire logic        port_latch_tx,
  input  wire logic        tx_serial_data,
  // Interrupt request
  output logic             rx_irq
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } aurx_state_type;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic       port_enable, nine_bit_rx_sel, continuous_receive_en, addr_detect_en;
  logic       sync_sel, high_speed_baud_sel;
  logic [7:0] baud_divisor;
  logic       rx_irq_en, periph_irq_en, global_irq_en;
  logic       overrun_flag;

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic        aw_held, w_held;
  logic [4:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire         byte0   = w_strb[0];
  wire         wr_rxs  = wr_fire & byte0 & (aw_addr == aurx_pkg::OFF_RX_STATUS);
  wire         wr_txs  = wr_fire & byte0 & (aw_addr == aurx_pkg::OFF_TX_STATUS);
  wire         wr_baud = wr_fire & byte0 & (aw_addr == aurx_pkg::OFF_BAUD_DIV);
  wire         wr_irq  = wr_fire & byte0 & (aw_addr == aurx_pkg::OFF_IRQ_CTRL);
  wire         wr_map  = (aw_addr == aurx_pkg::OFF_RX_DATA) | (aw_addr == aurx_pkg::OFF_RX_STATUS)
                       | (aw_addr == aurx_pkg::OFF_TX_STATUS) | (aw_addr == aurx_pkg::OFF_BAUD_DIV)
                       | (aw_addr == aurx_pkg::OFF_IRQ_CTRL);
  wire         rd_fire = s_axi_arvalid & s_axi_arready;
  wire [4:0]   rd_addr = {s_axi_araddr[4:2], 2'h0};
  wire         rd_data = rd_fire & (rd_addr == aurx_pkg::OFF_RX_DATA);

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 5'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= aurx_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[4:2], 2'h0};
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? aurx_pkg::RESP_OKAY : aurx_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      port_enable           <= 1'b0;
      nine_bit_rx_sel       <= 1'b0;
      continuous_receive_en <= 1'b0;
      addr_detect_en        <= 1'b0;
      sync_sel              <= 1'b0;
      high_speed_baud_sel   <= 1'b0;
      baud_divisor          <= aurx_pkg::RESET_BYTE;
      rx_irq_en             <= 1'b0;
      periph_irq_en         <= 1'b0;
      global_irq_en         <= 1'b0;
    end else begin
      if (wr_rxs) begin
        port_enable           <= w_data[aurx_pkg::BIT_PORT_EN];
        nine_bit_rx_sel       <= w_data[aurx_pkg::BIT_NINE_SEL];
        continuous_receive_en <= w_data[aurx_pkg::BIT_CONT_RX];
        addr_detect_en        <= w_data[aurx_pkg::BIT_ADDR_DET];
      end
      if (wr_txs) begin
        sync_sel            <= w_data[aurx_pkg::BIT_SYNC_SEL];
        high_speed_baud_sel <= w_data[aurx_pkg::BIT_HIGH_SPD];
      end
      if (wr_baud) begin
        baud_divisor <= w_data[7:0];
      end
      if (wr_irq) begin
        rx_irq_en     <= w_data[aurx_pkg::BIT_RX_IRQ_EN];
        periph_irq_en <= w_data[aurx_pkg::BIT_PER_IRQ];
        global_irq_en <= w_data[aurx_pkg::BIT_GLB_IRQ];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin steering
  // ----------------------------------------------------------------------
  // Direction bit 1 means input; with the port on, both are overridden
  assign receive_pin_oe   = port_enable ? 1'b0 : ~pin_direction_rx;       // [RL4]
  assign receive_pin_out  = port_latch_rx;
  assign transmit_pin_oe  = port_enable ? 1'b1 : ~pin_direction_tx;       // [RL4]
  assign transmit_pin_out = port_enable ? tx_serial_data : port_latch_tx; // [RL4]

  // ----------------------------------------------------------------------
  // Receive pin synchroniser: a change counts once stages 2 and 3 agree
  // ----------------------------------------------------------------------
  logic rx_s1, rx_s2, rx_s3, rx_level, rx_prev;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
      rx_level <= 1'b1;
      rx_prev  <= 1'b1;
    end else begin
      rx_s1   <= receive_pin_in;
      rx_s2   <= rx_s1;
      rx_s3   <= rx_s2;
      rx_prev <= rx_level;
      if (rx_s2 == rx_s3) begin
        rx_level <= rx_s3;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Baud timer: one tick per oversample
  // ----------------------------------------------------------------------
  logic [7:0] baud_count;
  logic [1:0] prescale;
  wire        rx_active = continuous_receive_en & ~sync_sel & port_enable; // [RL3]
  wire        baud_wrap = (baud_count == baud_divisor);
  // Low speed needs four times as many clocks per oversample
  wire        os_tick   = baud_wrap & (high_speed_baud_sel
                                       | (prescale == aurx_pkg::LOW_SPD_DIV)); // [RL22]

  always_ff @(posedge clock) begin
    if (!resetn || wr_baud) begin // [RL23]
      baud_count <= 8'h00;
      prescale   <= 2'h0;
    end else if (baud_wrap) begin
      baud_count <= 8'h00;
      prescale   <= prescale + 2'h1;
    end else begin
      baud_count <= baud_count + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Data recovery
  // ----------------------------------------------------------------------
  aurx_state_type state, next_state;
  logic [3:0] os_count;
  logic [2:0] votes;
  logic [3:0] bit_index;
  logic [8:0] rx_shift_reg;

  // Votes hold the three latest oversamples, the newest taken one tick before the centre tick
  wire        vote      = (votes[0] & votes[1]) | (votes[1] & votes[2])
                        | (votes[0] & votes[2]);                         // [RL24]
  wire        at_center = os_tick & (os_count == aurx_pkg::CENTER_TICK); // [RL1]
  wire        fall_edge = rx_prev & ~rx_level;
  wire [3:0]  last_bit  = nine_bit_rx_sel ? 4'h8 : 4'h7;
  wire        stop_seen = (state == ST_STOP) & at_center;
  wire [8:0]  shifted   = {vote, rx_shift_reg[8:1]};                     // [RL21]
  wire [8:0]  char_data = nine_bit_rx_sel ? rx_shift_reg
                                          : {1'b0, rx_shift_reg[8:1]};   // [RL17]

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (fall_edge) next_state = ST_START;
      ST_START: if (at_center) next_state = vote ? ST_IDLE : ST_DATA;   // [RL5]
      ST_DATA:  if (at_center && bit_index == last_bit) next_state = ST_STOP;
      ST_STOP:  if (at_center) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn || !rx_active) begin
      state        <= ST_IDLE;
      os_count     <= 4'h0;
      votes        <= 3'h7;
      bit_index    <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else begin
      state <= next_state;
      if (state == ST_IDLE) begin
        os_count  <= 4'h0;
        bit_index <= 4'h0;
      end else if (os_tick) begin
        os_count <= os_count + 4'h1;
      end
      if (os_tick) begin
        votes <= {votes[1:0], rx_level};
      end
      if (state == ST_DATA && at_center) begin
        rx_shift_reg <= shifted;          // [RL6]
        bit_index    <= bit_index + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Character FIFO
  // ----------------------------------------------------------------------
  logic [9:0] fifo_mem [aurx_pkg::FIFO_DEPTH];
  logic       wr_ptr, rd_ptr;
  logic [1:0] fifo_count;

  wire fifo_full  = (fifo_count == 2'h2);
  wire fifo_empty = (fifo_count == 2'h0);
  wire addr_skip  = addr_detect_en & nine_bit_rx_sel & ~char_data[8];    // [RL18]
  wire take_char  = stop_seen & ~addr_skip & ~overrun_flag;
  wire push       = take_char & ~fifo_full;                             // [RL8]
  wire pop        = rd_data & ~fifo_empty;                              // [RL9]
  wire [9:0] head = fifo_mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (!resetn || !port_enable) begin // [RL14]
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      fifo_count <= 2'h0;
      fifo_mem   <= '{default: 10'h000};
    end else begin
      if (push) begin
        fifo_mem[wr_ptr] <= {~vote, char_data}; // [RL7] [RL12]
        wr_ptr           <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop}; // [RL2]
    end
  end

  // Overrun sticks until either enable drops; it blocks further pushes
  always_ff @(posedge clock) begin
    if (!resetn || !continuous_receive_en || !port_enable) begin // [RL16]
      overrun_flag <= 1'b0;
    end else if (take_char && fifo_full) begin
      overrun_flag <= 1'b1; // [RL15]
    end
  end

  // ----------------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------------
  // Framing errors feed no interrupt term, only the status bit
  wire rx_pending_flag = rx_active & ~fifo_empty;                          // [RL10] [RL13]
  wire frame_err_flag  = ~fifo_empty & head[9];                            // [RL12]
  wire rx_ninth_bit    = ~fifo_empty & head[8];                            // [RL17]
  assign rx_irq = rx_pending_flag & rx_irq_en & periph_irq_en & global_irq_en; // [RL11]

  wire [7:0] rx_status_ctrl = {port_enable, nine_bit_rx_sel, 1'b0, continuous_receive_en,
                               addr_detect_en, frame_err_flag, overrun_flag, rx_ninth_bit};
  wire [7:0] tx_status_ctrl = {3'h0, sync_sel, 1'b0, high_speed_baud_sel, 2'h0};
  wire [7:0] irq_control    = {4'h0, rx_pending_flag, global_irq_en, periph_irq_en, rx_irq_en};
  wire [7:0] rx_data_reg    = fifo_empty ? 8'h00 : head[7:0];

  logic [7:0] rd_byte;
  logic       rd_map;
  always_comb begin
    rd_byte = 8'h00;
    rd_map  = 1'b1;
    case (rd_addr)
      aurx_pkg::OFF_RX_DATA:   rd_byte = rx_data_reg;
      aurx_pkg::OFF_RX_STATUS: rd_byte = rx_status_ctrl;
      aurx_pkg::OFF_TX_STATUS: rd_byte = tx_status_ctrl;
      aurx_pkg::OFF_BAUD_DIV:  rd_byte = baud_divisor;
      aurx_pkg::OFF_IRQ_CTRL:  rd_byte = irq_control;
      default:                 rd_map  = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= aurx_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_map ? aurx_pkg::RESP_OKAY : aurx_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_pending_flag: assert property (@(posedge clock) disable iff (!resetn) // [RL10]
    (push && rx_active) |=> (rx_pending_flag || !rx_active))
    else $error("pending flag does not follow fifo occupancy");

  a_irq_gating: assert property (@(posedge clock) disable iff (!resetn) // [RL11]
    rx_irq |-> (rx_irq_en && periph_irq_en && global_irq_en && fifo_count != 2'h0))
    else $error("interrupt raised without all enables");

  a_fifo_bound: assert property (@(posedge clock) disable iff (!resetn) // [RL2]
    fifo_count <= 2'h2)
    else $error("fifo holds more than two characters");

  a_overrun_set: assert property (@(posedge clock) disable iff (!resetn) // [RL15]
    (take_char && fifo_full && !pop && continuous_receive_en && port_enable)
      |=> (overrun_flag && fifo_count == 2'h2))
    else $error("overrun not flagged on third character");

  a_overrun_clear: assert property (@(posedge clock) disable iff (!resetn) // [RL16]
    (!continuous_receive_en || !port_enable) |=> !overrun_flag)
    else $error("overrun survives enable clear");

  a_start_abort: assert property (@(posedge clock) disable iff (!resetn) // [RL5]
    (state == ST_START && at_center && vote && rx_active) |=> (state == ST_IDLE && !push))
    else $error("false start not abandoned");

  a_port_reset: assert property (@(posedge clock) disable iff (!resetn) // [RL14]
    $fell(port_enable) |=> (fifo_count == 2'h0 && !frame_err_flag))
    else $error("port disable did not clear receiver");

  a_pin_force: assert property (@(posedge clock) disable iff (!resetn) // [RL4]
    port_enable |-> (!receive_pin_oe && transmit_pin_oe && transmit_pin_out == tx_serial_data))
    else $error("pins not forced while port enabled");

  a_addr_filter: assert property (@(posedge clock) disable iff (!resetn) // [RL18]
    (stop_seen && addr_detect_en && nine_bit_rx_sel && !char_data[8])
      |=> fifo_count <= $past(fifo_count))
    else $error("address filter let a data character in");

  a_pop_order: assert property (@(posedge clock) disable iff (!resetn) // [RL9]
    (pop && !push && port_enable) |=> fifo_count == $past(fifo_count) - 2'h1)
    else $error("data read did not remove head character");

endmodule

`default_nettype wire

// *** tb/aurx_line_model.sv ***
/*
  Remote asynchronous transmitter that drives the receive line.
  Assumes bit_clocks matches the receiver's clocks per bit at all times.
*/
`timescale 1ns/1ns
`default_nettype none

module aurx_line_model #(
  parameter int BIT_CLOCKS = 16
) (
  // Clock
  input  wire logic clock,
  // Serial line toward the receiver
  output logic      line
);
  // ----------------------------------------------------------------------
  // Frame generation
  // ----------------------------------------------------------------------
  // The line rests at the idle (mark) level between frames
  initial line = 1'h1;
  int bit_clocks = BIT_CLOCKS;

  task automatic send(input logic [8:0] data, input int bits, input logic stop);
    int i;
    @(posedge clock);
    line <= 1'h0;
    repeat (bit_clocks) @(posedge clock);
    for (i = 0; i < bits; i++) begin
      line <= data[i];
      repeat (bit_clocks) @(posedge clock);
    end
    line <= stop;
    repeat (bit_clocks) @(posedge clock);
    // One idle bit keeps frames apart and lets the store settle
    line <= 1'h1;
    repeat (bit_clocks) @(posedge clock);
  endtask

  // Short low pulse that never reaches the start centre
  task automatic glitch(input int clocks);
    @(posedge clock);
    line <= 1'h0;
    repeat (clocks) @(posedge clock);
    line <= 1'h1;
    repeat (3 * bit_clocks) @(posedge clock);
  endtask
endmodule

`default_nettype wire

// *** tb/tb.sv ***
/*
  Self-checking bench for the serial receiver: AXI4-Lite master tasks,
  random characters from a fixed seed, and line model frames.
  Assumes bready and rready may stay high throughout.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clock = 1'h0;
  logic        resetn = 1'h0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        pin_direction_rx = 1'h1, pin_direction_tx = 1'h1, port_latch_rx = 1'h0;
  logic        port_latch_tx = 1'h0, tx_serial_data = 1'h0;
  logic        receive_pin_in, receive_pin_out, receive_pin_oe;
  logic        transmit_pin_out, transmit_pin_oe, rx_irq;
  logic [31:0] seed = 32'h0000000B, r;
  logic [7:0]  b0, b1, b2;
  int          err_count = 0, cmp_count = 0;

  localparam logic [31:0] PE = 32'h1 << aurx_pkg::BIT_PORT_EN;
  localparam logic [31:0] NS = 32'h1 << aurx_pkg::BIT_NINE_SEL;
  localparam logic [31:0] CR = 32'h1 << aurx_pkg::BIT_CONT_RX;
  localparam logic [31:0] AD = 32'h1 << aurx_pkg::BIT_ADDR_DET;
  localparam logic [31:0] FE = 32'h1 << aurx_pkg::BIT_FRAME_ERR;
  localparam logic [31:0] OV = 32'h1 << aurx_pkg::BIT_OVERRUN;
  localparam logic [31:0] N9 = 32'h1 << aurx_pkg::BIT_NINTH;
  localparam logic [31:0] EN = 32'h7;
  localparam logic [31:0] PD = 32'h1 << aurx_pkg::BIT_PENDING;
  localparam logic [31:0] HS = 32'h1 << aurx_pkg::BIT_HIGH_SPD;
  localparam logic [31:0] SY = 32'h1 << aurx_pkg::BIT_SYNC_SEL;

  always #50 clock = ~clock;

  aurx_receiver aurx_receiver_inst (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .receive_pin_in, .receive_pin_out, .receive_pin_oe, .transmit_pin_out,
    .transmit_pin_oe, .pin_direction_rx, .pin_direction_tx, .port_latch_rx,
    .port_latch_tx, .tx_serial_data, .rx_irq);

  aurx_line_model #(.BIT_CLOCKS(16)) aurx_line_model_inst (.clock, .line(receive_pin_in));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Unmapped offsets answer with an error
  function automatic logic [1:0] resp_of(input logic [4:0] a);
    return (a > aurx_pkg::OFF_IRQ_CTRL) ? aurx_pkg::RESP_SLVERR : aurx_pkg::RESP_OKAY;
  endfunction

  task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk("bresp", {32'h0, resp_of(a)}, {32'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    chk("read", {resp_of(a), exp}, {s_axi_rresp, s_axi_rdata});
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'h1;
    r = rnd();
    {pin_direction_rx, pin_direction_tx, port_latch_rx, port_latch_tx, tx_serial_data} <= r[4:0];
    @(posedge clock);
    @(posedge clock);
    chk("pins_off", {30'h0, ~pin_direction_rx, ~pin_direction_tx, port_latch_rx, port_latch_tx},
        {30'h0, receive_pin_oe, transmit_pin_oe, receive_pin_out, transmit_pin_out});
    rd(aurx_pkg::OFF_RX_STATUS, 32'h0);
    rd(5'h14, 32'h0);
    wr(5'h14, 32'hFF);
    wr(aurx_pkg::OFF_BAUD_DIV, 32'h0);
    wr(aurx_pkg::OFF_TX_STATUS, HS);
    wr(aurx_pkg::OFF_RX_STATUS, PE);
    wr(aurx_pkg::OFF_IRQ_CTRL, EN | PD);
    rd(aurx_pkg::OFF_IRQ_CTRL, EN);
    wr(aurx_pkg::OFF_RX_STATUS, PE | CR);
    chk("pins_on", {32'h0, 1'h1, tx_serial_data},
        {32'h0, transmit_pin_oe, transmit_pin_out});
    chk("rx_oe_on", 34'h0, {33'h0, receive_pin_oe});
    r = rnd();
    b0 = r[7:0];
    aurx_line_model_inst.send({1'h0, b0}, 8, 1'h1);
    rd(aurx_pkg::OFF_IRQ_CTRL, EN | PD);
    chk("irq_on", 34'h1, {33'h0, rx_irq});
    wr(aurx_pkg::OFF_IRQ_CTRL, 32'h3);
    chk("irq_masked", 34'h0, {33'h0, rx_irq});
    rd(aurx_pkg::OFF_IRQ_CTRL, 32'h3 | PD);
    rd(aurx_pkg::OFF_RX_DATA, {24'h0, b0});
    rd(aurx_pkg::OFF_IRQ_CTRL, 32'h3);
    r = rnd();
    {b0, b1, b2} = r[23:0];
    aurx_line_model_inst.send({1'h0, b0}, 8, 1'h0);
    aurx_line_model_inst.send({1'h0, b1}, 8, 1'h1);
    aurx_line_model_inst.send({1'h0, b2}, 8, 1'h1);
    rd(aurx_pkg::OFF_RX_STATUS, PE | CR | FE | OV);
    rd(aurx_pkg::OFF_RX_DATA, {24'h0, b0});
    rd(aurx_pkg::OFF_RX_STATUS, PE | CR | OV);
    rd(aurx_pkg::OFF_RX_DATA, {24'h0, b1});
    rd(aurx_pkg::OFF_RX_DATA, 32'h0);
    wr(aurx_pkg::OFF_RX_STATUS, PE);
    rd(aurx_pkg::OFF_RX_STATUS, PE);
    wr(aurx_pkg::OFF_RX_STATUS, PE | CR);
    aurx_line_model_inst.send({1'h0, b2}, 8, 1'h0);
    wr(aurx_pkg::OFF_RX_STATUS, PE);
    rd(aurx_pkg::OFF_RX_STATUS, PE | FE);
    wr(aurx_pkg::OFF_RX_STATUS, 32'h0);
    rd(aurx_pkg::OFF_RX_STATUS, 32'h0);
    wr(aurx_pkg::OFF_RX_STATUS, PE | CR);
    aurx_line_model_inst.glitch(4);
    rd(aurx_pkg::OFF_IRQ_CTRL, 32'h3);
    wr(aurx_pkg::OFF_TX_STATUS, HS | SY);
    rd(aurx_pkg::OFF_TX_STATUS, HS | SY);
    aurx_line_model_inst.send({1'h0, b1}, 8, 1'h1);
    rd(aurx_pkg::OFF_IRQ_CTRL, 32'h3);
    wr(aurx_pkg::OFF_TX_STATUS, HS);
    aurx_line_model_inst.send({1'h0, b0}, 8, 1'h1);
    rd(aurx_pkg::OFF_RX_DATA, {24'h0, b0});
    wr(aurx_pkg::OFF_RX_STATUS, PE | NS | AD | CR);
    aurx_line_model_inst.send({1'h0, b1}, 9, 1'h1);
    rd(aurx_pkg::OFF_IRQ_CTRL, 32'h3);
    aurx_line_model_inst.send({1'h1, b2}, 9, 1'h1);
    rd(aurx_pkg::OFF_RX_STATUS, PE | NS | AD | CR | N9);
    rd(aurx_pkg::OFF_RX_DATA, {24'h0, b2});
    wr(aurx_pkg::OFF_RX_STATUS, PE | CR);
    wr(aurx_pkg::OFF_BAUD_DIV, 32'h1);
    wr(aurx_pkg::OFF_TX_STATUS, 32'h0);
    rd(aurx_pkg::OFF_BAUD_DIV, 32'h1);
    aurx_line_model_inst.bit_clocks = 128;
    aurx_line_model_inst.send({1'h0, b1}, 8, 1'h1);
    rd(aurx_pkg::OFF_RX_DATA, {24'h0, b1});
    close_out();
  end

  initial begin
    #2000000;
    err_count++;
    close_out();
  end
endmodule

`default_nettype wire
